/* logic/gdc_ctrl.v */
// Sixteen-channel gate and delay generator with APB register access
//
// What this block does
// - 8-bit codes, 256 steps over 500 ns
// - Single mode: input k drives output k
// - Dual mode: input k drives k and k+8
// - Inhibit suppresses gates starting during it
// - Abort input resets every channel at once
// - Monitors follow selected channel's triggered pulse
// - Delay write stores code for channel n
// - Gate write stores code for channel n
// - Select write picks monitor channel n
// - Commit applies all stored codes together
// - Codes retained; channels run after commit
// - Config light on in single mode
// - Presence light follows channel input level
// - Test pulse fires every channel
// - Delay is 15 ns plus 12% plus code
// - Gate is 10 ns plus 12% plus code
// - Test write fires an internal test
// - Module reset write and crate init reset
// - Valid functions answer without error
`timescale 1ns/1ps
`include "gdc_map.vh"

module gdc_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Front panel and board inputs
  input wire [15:0] chanIn,
  input wire inhibitIn,
  input wire abortIn,
  input wire testIn,
  input wire configSwitch,
  input wire crateInit,
  // Outputs and indicators
  output reg [15:0] chanOut,
  output reg monitorOutA,
  output reg monitorOutB,
  output reg [15:0] presenceLed,
  output reg configLed
);

  // ----------------------------------------------------------
  // Channel states
  // ----------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_GATE = 2'b10;

  // Cycle count for an offset and a code, rounded up
  function [7:0] toCycles;
    input [31:0] ofsNs;
    input [7:0] code;
    reg [31:0] t;
    reg [31:0] d;
    reg [31:0] n;
    begin
      t = (ofsNs * 32'd100 + `GDC_FS_PCT * `GDC_FS_NS) * `GDC_STEPS
        + {24'h000000, code} * `GDC_FS_NS * 32'd100;
      d = `GDC_PERIOD_NS * 32'd100 * `GDC_STEPS;
      n = (t + d - 32'd1) / d;
      // Full-scale code stays below 256 cycles, so the low byte is exact
      toCycles = n[7:0];
    end
  endfunction

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  reg [20:0] syncA;
  reg [20:0] syncB;
  reg [20:0] syncC;
  wire [20:0] rawIn;
  assign rawIn = {crateInit, configSwitch, testIn, abortIn, inhibitIn,
    chanIn};

  // Two flops per pin, third stage only for edge detection
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncA <= 21'h00000;
      syncB <= 21'h00000;
      syncC <= 21'h00000;
    end
    else
    begin
      syncA <= rawIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  wire [15:0] inLvl;
  wire [15:0] inRise;
  wire inhibitLvl;
  wire abortLvl;
  wire testRise;
  wire cfgLvl;
  wire initLvl;
  assign inLvl = syncB[15:0];
  assign inRise = syncB[15:0] & ~syncC[15:0];
  assign inhibitLvl = syncB[16];
  assign abortLvl = syncB[17];
  assign testRise = syncB[18] & ~syncC[18];
  assign cfgLvl = syncB[19];
  assign initLvl = syncB[20];

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  wire setup;
  wire access;
  wire codeHit;
  wire isMonSel;
  wire isCommit;
  wire isTest;
  wire isMReset;
  wire isStatus;
  wire badAddr;
  wire [3:0] chIdx;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign chIdx = paddr[5:2];
  assign codeHit = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
  assign isMonSel = (paddr == `GDC_MONSEL);
  assign isCommit = (paddr == `GDC_COMMIT);
  assign isTest = (paddr == `GDC_TEST);
  assign isMReset = (paddr == `GDC_MRESET);
  assign isStatus = (paddr == `GDC_STATUS);
  assign badAddr = ~(codeHit | isMonSel | isCommit | isTest | isMReset
    | isStatus) | (isStatus & pwrite);

  // Zero wait states; error for an unmapped function or a status write
  assign pready = 1'b1;
  assign pslverr = access & badAddr;

  wire wrEn;
  wire dlyWr;
  wire gateWr;
  wire commitWr;
  wire testWr;
  wire mresetWr;
  assign wrEn = access & pwrite & ~badAddr;
  assign dlyWr = wrEn & codeHit & ~paddr[6];
  assign gateWr = wrEn & codeHit & paddr[6];
  assign commitWr = wrEn & isCommit;
  assign testWr = wrEn & isTest;
  assign mresetWr = wrEn & isMReset;

  // ----------------------------------------------------------
  // Staging storage, kept without reset like retained memory
  // ----------------------------------------------------------
  reg [7:0] stageDly [0:15];
  reg [7:0] stageGate [0:15];

  // Code writes land only in staging
  always @(posedge core_clk)
  begin
    if (dlyWr)
      stageDly[chIdx] <= pwdata[7:0];
    if (gateWr)
      stageGate[chIdx] <= pwdata[7:0];
  end

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  reg [3:0] monSel;
  reg live;
  reg dualMode;
  reg [1:0] cfgCnt;
  wire modReset;
  assign modReset = mresetWr | initLvl;

  // Monitor select, commit state and power-on configuration
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      monSel <= 4'h0;
      live <= 1'b0;
      dualMode <= 1'b0;
      cfgCnt <= 2'h0;
      configLed <= 1'b0;
    end
    else
    begin
      if (cfgCnt != `GDC_CFG_WAIT)
      begin
        cfgCnt <= cfgCnt + 2'h1;
        if (cfgCnt == `GDC_CFG_WAIT - 2'h1)
        begin
          dualMode <= ~cfgLvl;
          configLed <= cfgLvl;
        end
      end
      if (modReset)
      begin
        monSel <= 4'h0;
        live <= 1'b0;
      end
      else
      begin
        if (wrEn & isMonSel)
          monSel <= pwdata[3:0];
        if (commitWr)
          live <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // Active timing, loaded only on commit
  // ----------------------------------------------------------
  reg [7:0] actDly [0:15];
  reg [7:0] actGate [0:15];
  integer i;

  // Commit converts every staged code to cycle counts at once
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 16; i = i + 1)
      begin
        actDly[i] <= 8'h01;
        actGate[i] <= 8'h01;
      end
    end
    else if (commitWr)
    begin
      for (i = 0; i < 16; i = i + 1)
      begin
        actDly[i] <= toCycles(`GDC_DLY_OFS_NS, stageDly[i]);
        actGate[i] <= toCycles(`GDC_GATE_OFS_NS, stageGate[i]);
      end
    end
  end

  // ----------------------------------------------------------
  // Trigger routing
  // ----------------------------------------------------------
  wire testFire;
  wire [15:0] fire;
  assign testFire = testRise | testWr;
  // Dual mode copies inputs 0..7 onto both halves
  assign fire = ({16{testFire}}
    | (dualMode ? {inRise[7:0], inRise[7:0]} : inRise))
    & {16{live}};

  // ----------------------------------------------------------
  // Channel sequencers
  // ----------------------------------------------------------
  reg [1:0] chState [0:15];
  reg [7:0] chCnt [0:15];
  integer k;

  // Per channel: wait delay, then open gate unless inhibited
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (k = 0; k < 16; k = k + 1)
      begin
        chState[k] <= ST_IDLE;
        chCnt[k] <= 8'h00;
        chanOut[k] <= 1'b0;
      end
    end
    else
    begin
      for (k = 0; k < 16; k = k + 1)
      begin
        if (abortLvl | modReset)
        begin
          chState[k] <= ST_IDLE;
          chCnt[k] <= 8'h00;
          chanOut[k] <= 1'b0;
        end
        else
        begin
          case (chState[k])
            ST_IDLE:
            begin
              chanOut[k] <= 1'b0;
              if (fire[k])
              begin
                chState[k] <= ST_DELAY;
                chCnt[k] <= actDly[k] - 8'h01;
              end
            end
            ST_DELAY:
            begin
              if (chCnt[k] != 8'h00)
                chCnt[k] <= chCnt[k] - 8'h01;
              else if (inhibitLvl)
                chState[k] <= ST_IDLE;
              else
              begin
                chState[k] <= ST_GATE;
                chCnt[k] <= actGate[k] - 8'h01;
                chanOut[k] <= 1'b1;
              end
            end
            ST_GATE:
            begin
              if (chCnt[k] != 8'h00)
                chCnt[k] <= chCnt[k] - 8'h01;
              else
              begin
                chState[k] <= ST_IDLE;
                chanOut[k] <= 1'b0;
              end
            end
            default:
            begin
              chState[k] <= ST_IDLE;
              chanOut[k] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Monitors and presence indicators
  // ----------------------------------------------------------
  wire monNext;
  // A channel gates after a test, its own input in single mode or, in dual mode, input k mod 8, so this is its pulse
  assign monNext = (abortLvl | modReset) ? 1'b0 : chanOut[monSel];

  // Registered copies of the selected gate and the input levels
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      monitorOutA <= 1'b0;
      monitorOutB <= 1'b0;
      presenceLed <= 16'h0000;
    end
    else
    begin
      monitorOutA <= monNext;
      monitorOutB <= monNext;
      presenceLed <= inLvl;
    end
  end

  // ----------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------
  reg [31:0] next_prdata;
  always @*
  begin
    next_prdata = 32'h00000000;
    if (codeHit)
      next_prdata[7:0] = paddr[6] ? stageGate[chIdx] : stageDly[chIdx];
    else if (isMonSel)
      next_prdata[3:0] = monSel;
    else if (isStatus)
    begin
      next_prdata[`GDC_ST_PRES_LSB +: 16] = inLvl;
      next_prdata[`GDC_ST_DUAL] = dualMode;
      next_prdata[`GDC_ST_LIVE] = live;
      next_prdata[`GDC_ST_SEL_LSB +: 4] = monSel;
    end
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= next_prdata;
  end

endmodule // gdc_ctrl

/* logic/gdc_map.vh */
// Address map, field positions and timing constants of the gate/delay block
`ifndef GDC_MAP_VH
`define GDC_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define GDC_DLY_BASE 12'h000
`define GDC_GATE_BASE 12'h040
`define GDC_MONSEL 12'h080
`define GDC_COMMIT 12'h084
`define GDC_TEST 12'h088
`define GDC_MRESET 12'h08C
`define GDC_STATUS 12'h090

// ------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------
`define GDC_ST_PRES_LSB 0
`define GDC_ST_DUAL 16
`define GDC_ST_LIVE 17
`define GDC_ST_SEL_LSB 18

// ------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------
`define GDC_STEPS 32'd256
`define GDC_FS_NS 32'd500
`define GDC_FS_PCT 32'd12
`define GDC_DLY_OFS_NS 32'd15
`define GDC_GATE_OFS_NS 32'd10
`define GDC_PERIOD_NS 32'd4
`define GDC_CFG_WAIT 2'h3

`endif

/* dv/gdc_apb_host.sv */
// Crate controller model driving the register bus
`timescale 1ns/1ps

module gdc_apb_host (
  // Clock
  input wire core_clk,
  // Bus
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [11:0] paddr,
  output reg [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata
);
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // One transfer; code writes and commits go through it
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge core_clk);
  endtask
endmodule // gdc_apb_host

/* dv/gdc_ctrl_assertions.sv */
// Port checker of the gate/delay block
`timescale 1ns/1ps
`include "gdc_map.vh"

module gdc_ctrl_assertions (
  // Clock, reset and bus
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Channels
  input wire [15:0] chanIn,
  input wire abortIn,
  input wire [15:0] chanOut,
  input wire monitorOutA,
  input wire monitorOutB,
  input wire [15:0] presenceLed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Abort held long enough to pass its synchroniser
  sequence abortHeld;
    abortIn [*4];
  endsequence

  // Bus answers
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_map_ok: assert property (psel && penable && paddr < `GDC_STATUS
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on valid");
  a_bad_addr: assert property (psel && penable && paddr > `GDC_STATUS
    |-> pslverr) else $error("no error on unmapped");
  a_status_ro: assert property (psel && penable && pwrite
    && paddr == `GDC_STATUS |-> pslverr) else $error("status written");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");

  // Channel outputs
  a_mon_pair: assert property (monitorOutA == monitorOutB)
    else $error("monitors differ");
  a_mon_source: assert property (monitorOutA |-> $past(chanOut) != 0)
    else $error("monitor without gate");
  a_abort_idle: assert property (abortHeld |-> chanOut == 16'h0000)
    else $error("output during abort");
  a_presence: assert property (presenceLed == $past(chanIn, 3))
    else $error("presence lag");
endmodule // gdc_ctrl_assertions

bind gdc_ctrl gdc_ctrl_assertions chk (.core_clk(core_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .chanIn(chanIn), .abortIn(abortIn),
  .chanOut(chanOut), .monitorOutA(monitorOutA), .monitorOutB(monitorOutB),
  .presenceLed(presenceLed));

/* dv/gdc_ctrl_bench.sv */
// Self-checking bench of the gate/delay block
`timescale 1ns/1ps
`include "gdc_map.vh"

module gdc_ctrl_bench;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, e, mon;
  logic inhibitIn, abortIn, testIn, configSwitch, crateInit;
  logic monitorOutA, monitorOutB, configLed;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] chanIn, chanOut, presenceLed, seen;
  int fail_count, checks, cyc, dly, wid, i;

  // Design and bus master
  gdc_ctrl dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .chanIn(chanIn), .inhibitIn(inhibitIn), .abortIn(abortIn),
    .testIn(testIn), .configSwitch(configSwitch), .crateInit(crateInit),
    .chanOut(chanOut), .monitorOutA(monitorOutA),
    .monitorOutB(monitorOutB), .presenceLed(presenceLed),
    .configLed(configLed));
  gdc_apb_host host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata));

  // Clock and hang limit
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      print_verdict;
    end
  end

  task print_verdict;
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, y);
    checks++;
    if (x !== y)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, x, y);
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h000000, d}, q, e);
    chk("wr err", 0, e);
  endtask

  task t_reset(input logic sw);
    nrst <= 1'b0;
    configSwitch <= sw;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("cfgLed", sw, configLed);
  endtask

  // Pulse one input, measure delay and width; spacing kept by source
  // Delay count: two sync cycles, the idle cycle that loads the delay, the delay, and the negedge that sees it
  task fire(input int ch);
    chanIn[ch] <= 1'b1;
    dly = 0;
    seen = 0;
    mon = 0;
    while (chanOut[ch] !== 1'b1 && dly < 400)
    begin
      @(negedge core_clk);
      dly++;
      seen |= chanOut;
    end
    wid = 0;
    while (chanOut[ch] === 1'b1 && wid < 400)
    begin
      @(negedge core_clk);
      wid++;
      seen |= chanOut;
      mon |= monitorOutA;
    end
    @(posedge core_clk);
    chanIn[ch] <= 1'b0;
    repeat (300) @(posedge core_clk);
  endtask

  task t_bus;
    host.xfer(1'b0, 12'h0A0, 0, q, e);
    chk("unmapped", 1, e);
    host.xfer(1'b1, `GDC_STATUS, 0, q, e);
    chk("status wr", 1, e);
    wr(`GDC_DLY_BASE + 12'h00C, 8'hA5);
    host.xfer(1'b0, `GDC_DLY_BASE + 12'h00C, 0, q, e);
    chk("code rd", 32'h000000A5, q);
  endtask

  task t_single;
    for (i = 0; i < 16; i++)
    begin
      wr(`GDC_DLY_BASE + 12'(4 * i), 8'h00);
      wr(`GDC_GATE_BASE + 12'(4 * i), 8'h00);
    end
    wr(`GDC_MONSEL, 8'h00);
    wr(`GDC_COMMIT, 8'h00);
    fire(0);
    chk("delay0", 23, dly);
    chk("gate0", 18, wid);
    chk("outs", 16'h0001, seen);
    chk("mon", 1, mon);
  endtask

  task t_test;
    for (i = 0; i < 2; i++)
    begin
      if (i == 0)
        wr(`GDC_TEST, 8'h00);
      else
        testIn <= 1'b1;
      @(posedge core_clk);
      testIn <= 1'b0;
      dly = 0;
      while (chanOut !== 16'hFFFF && dly < 400)
      begin
        @(negedge core_clk);
        dly++;
      end
      chk("test all", 16'hFFFF, chanOut);
      @(negedge core_clk);
      chk("test mon", 1, monitorOutA);
      repeat (300) @(posedge core_clk);
    end
  endtask

  task t_stage;
    wr(`GDC_DLY_BASE, 8'hFF);
    fire(0);
    chk("staged", 23, dly);
    wr(`GDC_MONSEL, 8'h05);
    wr(`GDC_COMMIT, 8'h00);
    fire(0);
    chk("delay255", 148, dly);
    chk("mon off", 0, mon);
  endtask

  task t_block;
    inhibitIn <= 1'b1;
    fire(1);
    chk("inhibit", 0, seen);
    inhibitIn <= 1'b0;
    chanIn[2] <= 1'b1;
    repeat (10) @(posedge core_clk);
    abortIn <= 1'b1;
    chanIn[2] <= 1'b0;
    // Look inside the gate window that channel 2 would have had
    repeat (20) @(posedge core_clk);
    chk("abort", 0, chanOut);
    repeat (180) @(posedge core_clk);
    abortIn <= 1'b0;
    chk("abort end", 0, chanOut);
    crateInit <= 1'b1;
    repeat (4) @(posedge core_clk);
    crateInit <= 1'b0;
    fire(1);
    chk("init", 0, seen);
    wr(`GDC_COMMIT, 8'h00);
    fire(1);
    chk("rearm", 16'h0002, seen);
    wr(`GDC_MRESET, 8'h00);
    fire(1);
    chk("mreset", 0, seen);
  endtask

  task t_dual;
    t_reset(1'b0);
    fire(0);
    chk("no commit", 0, seen);
    wr(`GDC_COMMIT, 8'h00);
    host.xfer(1'b0, `GDC_STATUS, 0, q, e);
    chk("status", 32'h00030000, q);
    fire(0);
    chk("dual", 16'h0101, seen);
  endtask

  initial
  begin
    {nrst, inhibitIn, abortIn, testIn, configSwitch, crateInit} = 0;
    chanIn = 0;
    t_reset(1'b1);
    t_bus;
    t_single;
    t_test;
    t_stage;
    t_block;
    t_dual;
    print_verdict;
  end
endmodule // gdc_ctrl_bench
